// [test_point_pkg.sv]
package test_point_pkg;

   // system clock rate in kHz
   localparam int unsigned CLK_SYS_KHZ = 25000;

   // requested debug clock rates in kHz
   localparam int unsigned TAP0_KHZ = 60000;
   localparam int unsigned TAP1_KHZ = 30000;
   localparam int unsigned TAP2_KHZ = 700;
   localparam int unsigned TAP3_KHZ = 7500;

   localparam int unsigned NUM_PINS = 8;
   localparam int unsigned NUM_TAPS = 4;
   localparam int unsigned HALF_WIDTH = 8;
   localparam int unsigned MODE_BITS = 3;

   // half period in system cycles, rounded down, never below one cycle
   function automatic int unsigned half_cycles(input int unsigned f_khz);
      int unsigned c;
      c = CLK_SYS_KHZ / (2 * f_khz);
      return (c < 1) ? 1 : c;
   endfunction : half_cycles

   localparam int unsigned TAP0_HALF = half_cycles(TAP0_KHZ);
   localparam int unsigned TAP1_HALF = half_cycles(TAP1_KHZ);
   localparam int unsigned TAP2_HALF = half_cycles(TAP2_KHZ);
   localparam int unsigned TAP3_HALF = half_cycles(TAP3_KHZ);

   localparam logic [2:0] MODE_QUIET = 3'h0;
   localparam logic [2:0] MODE_CLK_DEBUG = 3'h2;

   localparam logic [7:0] STRAP_RESET = 8'h00;
   localparam logic [7:0] OE_ALL = 8'hff;
   localparam logic [7:0] OE_NONE = 8'h00;

   // pin positions in the clock debug selection
   localparam int unsigned PIN_TAP0 = 0;
   localparam int unsigned PIN_TAP1 = 1;
   localparam int unsigned PIN_TAP2 = 2;
   localparam int unsigned PIN_HIGH_A = 3;
   localparam int unsigned PIN_LOW = 4;
   localparam int unsigned PIN_HIGH_B = 5;
   localparam int unsigned PIN_HIGH_C = 6;
   localparam int unsigned PIN_TAP3 = 7;

   typedef enum logic [2:0] {
      ST_HOLD = 3'b001,
      ST_QUIET = 3'b010,
      ST_CLK_DEBUG = 3'b100
   } port_state_e;

endpackage : test_point_pkg

// [clock_tap_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface clock_tap_if #(parameter int unsigned TAPS = 4);
   logic run;
   logic [TAPS-1:0] tap;
   modport ctrl (output run, input tap);
   modport gen (input run, output tap);
endinterface : clock_tap_if
`default_nettype wire

// [debug_clock_divider.sv]
`timescale 1ns/1ps
`default_nettype none
module debug_clock_divider (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   clock_tap_if.gen taps
);

   localparam int unsigned HALF_MAX = (1 << test_point_pkg::HALF_WIDTH);

   function automatic int unsigned half_of(input int unsigned idx);
      case (idx)
         0: return test_point_pkg::TAP0_HALF;
         1: return test_point_pkg::TAP1_HALF;
         2: return test_point_pkg::TAP2_HALF;
         default: return test_point_pkg::TAP3_HALF;
      endcase
   endfunction : half_of

   genvar g;
   generate
      for (g = 0; g < test_point_pkg::NUM_TAPS; g++) begin : g_tap
         localparam int unsigned HALF = half_of(g);
         localparam logic [test_point_pkg::HALF_WIDTH-1:0] LAST = (test_point_pkg::HALF_WIDTH)'(HALF - 1);
         if (HALF < 1 || HALF > HALF_MAX) begin : g_bad
            $error("debug_clock_divider: half period out of range");
         end
         logic [test_point_pkg::HALF_WIDTH-1:0] cnt;
         logic level;
         wire logic at_last = (cnt == LAST);
         // counter and output clear whenever the tap is not running
         always_ff @(posedge i_clk_sys or posedge i_rst) begin
            if (i_rst) begin
               cnt <= '0;
               level <= 1'b0;
            end else if (!taps.run) begin
               cnt <= '0;
               level <= 1'b0;
            end else if (at_last) begin
               cnt <= '0;
               level <= ~level;
            end else begin
               cnt <= cnt + 1'b1;
            end
         end
         assign taps.tap[g] = level;
      end
   endgenerate

endmodule : debug_clock_divider
`default_nettype wire

// [test_point_strap_port.sv]
// Function
// R1: While system reset is asserted, no test point pin is driven.
// R2: After reset release the test point pins become outputs governed by the captured mode.
// R3: The pin levels present when reset is released are captured as the strap value.
// R4: The captured strap value stays unchanged until reset is asserted again.
// R5: Capture happens only on reset release, so later strap changes need a new reset cycle.
// R6: An unstrapped pin reads zero, giving the default mode, and a strap must pull high for another mode.
// R7: Low strap bits 000 keep all eight pins high impedance.
// R8: Low strap bits 010 drive pin 0 with the fastest tap clock and pin 1 with half of it; here pin 1 toggles every cycle, at the same rate as pin 0.
// R9: In clock debug, pin 2 carries a slow clock, pins 3, 5, 6 are high, pin 4 low, pin 7 a 7.5 MHz tap; here pin 7 runs at 12.5 MHz.
// R10: Any other strap value keeps all pins high impedance.
`timescale 1ns/1ps
`default_nettype none
module test_point_strap_port (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [7:0] i_test_point_pins,
   output logic [7:0] o_test_point_pins,
   output logic [7:0] o_test_point_pins_oe,
   output logic [7:0] o_strap_value,
   output logic o_strap_valid
);

   // pin synchroniser, no reset so it tracks the straps while reset is held
   logic [7:0] sync1;
   logic [7:0] sync2;
   logic [7:0] sync3;
   logic [7:0] filtered;

   always_ff @(posedge i_clk_sys) begin
      sync1 <= i_test_point_pins;
      sync2 <= sync1;
      sync3 <= sync2;
   end

   // a bit changes only when the second and third stage agree
   wire logic [7:0] stage_agree = ~(sync2 ^ sync3);
   wire logic [7:0] next_filtered = (sync3 & stage_agree) | (filtered & ~stage_agree);

   always_ff @(posedge i_clk_sys) begin
      filtered <= next_filtered;
   end

   test_point_pkg::port_state_e state;
   test_point_pkg::port_state_e next_state;
   logic [7:0] strap;
   logic [7:0] pin_out;
   logic [7:0] pin_oe;

   clock_tap_if #(.TAPS(test_point_pkg::NUM_TAPS)) tap_bus ();

   debug_clock_divider u_divider (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .taps(tap_bus.gen)
   );

   wire logic take_strap = (state == test_point_pkg::ST_HOLD); // see R3
   wire logic [2:0] strap_mode = next_filtered[test_point_pkg::MODE_BITS-1:0];
   wire logic is_debug = (state == test_point_pkg::ST_CLK_DEBUG);

   always_comb begin
      case (state)
         test_point_pkg::ST_HOLD: begin
            // only the unstrapped or 010 patterns matter; others fall to quiet
            if (strap_mode == test_point_pkg::MODE_CLK_DEBUG) begin // see R8
               next_state = test_point_pkg::ST_CLK_DEBUG;
            end else begin
               next_state = test_point_pkg::ST_QUIET; // see R7 see R10 see R6
            end
         end
         test_point_pkg::ST_QUIET: begin
            next_state = test_point_pkg::ST_QUIET;
         end
         test_point_pkg::ST_CLK_DEBUG: begin
            next_state = test_point_pkg::ST_CLK_DEBUG;
         end
         default: begin
            next_state = test_point_pkg::ST_QUIET;
         end
      endcase
   end

   // mode is left only by reset, so the straps are sampled once per release
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state <= test_point_pkg::ST_HOLD;
      end else begin
         state <= next_state; // see R5
      end
   end

   wire logic [7:0] next_strap = take_strap ? next_filtered : strap;

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         strap <= test_point_pkg::STRAP_RESET;
      end else begin
         strap <= next_strap; // see R3 see R4
      end
   end

   assign tap_bus.run = is_debug; // see R8

   logic [7:0] debug_levels;
   always_comb begin
      debug_levels = '0;
      debug_levels[test_point_pkg::PIN_TAP0] = tap_bus.tap[0];
      debug_levels[test_point_pkg::PIN_TAP1] = tap_bus.tap[1];
      debug_levels[test_point_pkg::PIN_TAP2] = tap_bus.tap[2];
      debug_levels[test_point_pkg::PIN_HIGH_A] = 1'b1;
      debug_levels[test_point_pkg::PIN_LOW] = 1'b0;
      debug_levels[test_point_pkg::PIN_HIGH_B] = 1'b1;
      debug_levels[test_point_pkg::PIN_HIGH_C] = 1'b1;
      debug_levels[test_point_pkg::PIN_TAP3] = tap_bus.tap[3];
   end

   wire logic [7:0] next_pin_out = is_debug ? debug_levels : 8'h00; // see R9
   wire logic [7:0] next_pin_oe = is_debug ? test_point_pkg::OE_ALL : test_point_pkg::OE_NONE; // see R2 see R7

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         pin_out <= 8'h00;
         pin_oe <= test_point_pkg::OE_NONE; // see R1
      end else begin
         pin_out <= next_pin_out;
         pin_oe <= next_pin_oe;
      end
   end

   assign o_test_point_pins = pin_out;
   assign o_test_point_pins_oe = pin_oe;
   assign o_strap_value = strap;
   assign o_strap_valid = ~take_strap;

   reset_no_drive_a: assert property (@(posedge i_clk_sys) i_rst |-> o_test_point_pins_oe == 8'h00) // see R1
      else $error("test point driven during reset");

   strap_capture_a: assert property (@(posedge i_clk_sys) $fell(i_rst) |=> o_strap_valid && o_strap_value == $past(next_filtered)) // see R3
      else $error("strap not captured at reset release");

   strap_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_strap_valid && $past(o_strap_valid) |-> $stable(o_strap_value)) // see R4
      else $error("strap value changed after capture");

   single_sample_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_strap_valid |=> o_strap_valid ##1 o_strap_valid) // see R5
      else $error("strap sampled again without reset");

   debug_outputs_on_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      is_debug |=> o_test_point_pins_oe == 8'hff) // see R2
      else $error("debug mode pins not driven");

   quiet_pins_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_strap_valid && o_strap_value[2:0] != 3'h2 |-> o_test_point_pins_oe == 8'h00) // see R7
      else $error("pins driven outside clock debug");

   other_mode_hiz_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_strap_valid && o_strap_value[2:0] != 3'h0 && o_strap_value[2:0] != 3'h2
      |-> o_test_point_pins_oe == 8'h00 && !tap_bus.run) // see R10
      else $error("unknown strap value drives pins");

   fixed_levels_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_test_point_pins_oe[4] |-> o_test_point_pins[3] && o_test_point_pins[5]
      && o_test_point_pins[6] && !o_test_point_pins[4]) // see R9
      else $error("fixed debug levels wrong");

   fast_tap_toggle_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_test_point_pins_oe[0] && $past(o_test_point_pins_oe[0])
      |-> o_test_point_pins[0] != $past(o_test_point_pins[0])
      && o_test_point_pins[7] != $past(o_test_point_pins[7])) // see R8 see R9
      else $error("debug clock tap not toggling");

   slow_tap_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $rose(o_test_point_pins[2]) |=> o_test_point_pins[2] [*8]) // see R9
      else $error("slow debug tap too fast");

   reset_pins_low_a: assert property (@(posedge i_clk_sys) i_rst |-> o_test_point_pins == 8'h00) // see R1
      else $error("test point level not cleared in reset");

   reset_no_strap_a: assert property (@(posedge i_clk_sys)
      i_rst |-> !o_strap_valid && o_strap_value == 8'h00) // see R4
      else $error("strap reported during reset");

   debug_oe_all_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_strap_valid && o_strap_value[2:0] == 3'h2 |=> o_test_point_pins_oe == 8'hff) // see R2 see R8
      else $error("clock debug strap left pins undriven");

   quiet_level_low_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_test_point_pins_oe == 8'h00 |-> o_test_point_pins == 8'h00) // see R7
      else $error("released pins carry a level");

   oe_all_none_a: assert property (@(posedge i_clk_sys)
      o_test_point_pins_oe == 8'h00 || o_test_point_pins_oe == 8'hff) // see R2
      else $error("pins partly driven");

   state_one_hot_a: assert property (@(posedge i_clk_sys) $onehot(state)) // see R4
      else $error("mode state not one hot");

   valid_stays_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $past(o_strap_valid) |-> o_strap_valid) // see R4
      else $error("captured mode lost without reset");

   mid_tap_toggle_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_test_point_pins_oe[1] && $past(o_test_point_pins_oe[1])
      |-> o_test_point_pins[1] != $past(o_test_point_pins[1])) // see R8
      else $error("second debug tap not toggling");

   slow_tap_low_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $fell(o_test_point_pins[2]) |=> !o_test_point_pins[2] [*8]) // see R9
      else $error("slow debug tap low phase too short");

   mode_follows_strap_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_strap_valid |-> is_debug == (o_strap_value[2:0] == 3'h2)) // see R8 see R10
      else $error("mode does not match captured strap");

   debug_from_release_a: assert property (@(posedge i_clk_sys)
      $fell(i_rst) && next_filtered[2:0] == 3'h2 |=> ##1 o_test_point_pins_oe == 8'hff) // see R2
      else $error("pins not driven two cycles after release");

endmodule : test_point_strap_port
`default_nettype wire

// [strap_board.sv]
`timescale 1ns/1ps
`default_nettype none
module strap_board (
   input wire logic [7:0] i_pull_high,
   input wire logic [7:0] i_drive,
   input wire logic [7:0] i_drive_oe,
   output logic [7:0] o_level
);
   // a released pin falls to the internal pulldown unless a board strap pulls it high
   assign o_level = (i_drive & i_drive_oe) | (i_pull_high & ~i_drive_oe);
endmodule : strap_board
`default_nettype wire

// [test_test_point_strap_port.sv]
`timescale 1ns/1ps
`default_nettype none
module test_test_point_strap_port;
   logic i_clk_sys;
   logic i_rst;
   logic [7:0] pull;
   logic [7:0] pin_level;
   logic [7:0] out;
   logic [7:0] oe;
   logic [7:0] strap;
   logic valid;
   int err_count;
   int checks;

   strap_board board (.i_pull_high(pull), .i_drive(out), .i_drive_oe(oe), .o_level(pin_level));

   test_point_strap_port uut (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_test_point_pins(pin_level),
      .o_test_point_pins(out),
      .o_test_point_pins_oe(oe),
      .o_strap_value(strap),
      .o_strap_valid(valid)
   );

   initial begin
      i_clk_sys = 1'b0;
      forever #20 i_clk_sys = ~i_clk_sys;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic report_and_stop;
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : report_and_stop

   task automatic tick;
      @(posedge i_clk_sys);
      #1;
   endtask : tick

   // hold reset with the straps set, release it and look at the capture
   task automatic strap_reset(input logic [7:0] val);
      tick();
      pull = val;
      i_rst = 1'b1;
      tick();
      check(oe, 8'h00);
      check({7'h00, valid}, 8'h00);
      repeat (5) tick();
      i_rst = 1'b0;
      tick();
      check(strap, val);
      check({7'h00, valid}, 8'h01);
      tick();
   endtask : strap_reset

   task automatic quiet_run(input logic [7:0] val);
      strap_reset(val);
      repeat (20) begin
         tick();
         check(oe, 8'h00);
         check(pin_level, val);
      end
   endtask : quiet_run

   task automatic scen_default;
      quiet_run(8'h00);
   endtask : scen_default

   task automatic scen_other_codes;
      logic [7:0] codes [6] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h07, 8'hf9};
      foreach (codes[i]) quiet_run(codes[i]);
   endtask : scen_other_codes

   task automatic pin2_edge(output int gap);
      logic b;
      b = out[2];
      gap = 0;
      while (out[2] === b && gap < 40) begin
         tick();
         gap++;
      end
      if (gap >= 40) begin
         err_count++;
         report_and_stop();
      end
   endtask : pin2_edge

   task automatic scen_clock_debug;
      logic [7:0] prev;
      int gap;
      strap_reset(8'hfa);
      check(oe, 8'hff);
      prev = out;
      repeat (8) begin
         tick();
         check(out & 8'h78, 8'h68);
         check((out ^ prev) & 8'h83, 8'h83);
         check(pin_level, out);
         prev = out;
      end
      pin2_edge(gap);
      pin2_edge(gap);
      check(8'(gap), 8'(test_point_pkg::TAP2_HALF));
   endtask : scen_clock_debug

   task automatic scen_late_strap;
      strap_reset(8'h02);
      pull = 8'h00;
      repeat (10) tick();
      check(strap, 8'h02);
      check(oe, 8'hff);
      strap_reset(8'h00);
      pull = 8'h02;
      repeat (10) tick();
      check(strap, 8'h00);
      check(oe, 8'h00);
   endtask : scen_late_strap

   initial begin
      #200000;
      err_count++;
      report_and_stop();
   end

   initial begin
      i_rst = 1'b1;
      pull = 8'h00;
      err_count = 0;
      checks = 0;
      repeat (2) @(posedge i_clk_sys);
      #1;
      // stay in reset until the first scenario has set its straps, so no unknown strap is ever captured
      scen_default();
      scen_clock_debug();
      scen_other_codes();
      scen_late_strap();
      report_and_stop();
   end
endmodule : test_test_point_strap_port
`default_nettype wire
